// [ext_temp_pkg.sv]
package ext_temp_pkg;

	// ==========================================================
	// Bus geometry
	localparam int          ADR_W          = 16;
	localparam int          DAT_W          = 32;
	localparam int          SEL_W          = 4;
	localparam int          BYTE_W         = 8;
	localparam int          TEMP_W         = 16;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_TEMP_LOW   = 16'h2900;
	localparam logic [15:0] IDX_TEMP_HIGH  = 16'h2901;
	localparam logic [15:0] IDX_SRC_SEL    = 16'h2902;
	localparam logic [15:0] IDX_TEMP_STAT  = 16'h2910;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  RST_TEMP_BYTE  = 8'h00;
	localparam logic [7:0]  RST_SRC_SEL    = 8'h00;

	// ==========================================================
	// Field positions
	localparam int          SEL_CH2_BIT    = 2;
	localparam int          FRAC_MSB       = 6;
	localparam int          INT_LSB        = 7;
	localparam int          INT_MSB        = 14;
	localparam int          FRAC_W         = FRAC_MSB + 1;
	localparam int          INT_W          = INT_MSB - INT_LSB + 1;
	localparam int          STAT_PEND_BIT  = 16;
	localparam int          LANE0          = 0;

	// ==========================================================
	// Bus slave states, Gray ordered
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_e;

	// ==========================================================
	// One bus request as seen by the register bank
	typedef struct packed {
		logic [ADR_W-1:0] adr;
		logic             we;
		logic [SEL_W-1:0] sel;
		logic [DAT_W-1:0] dat;
	} bus_req_s;

	// Active temperature split into its fixed-point parts
	typedef struct packed {
		logic signed [INT_W-1:0] whole;
		logic [FRAC_W-1:0]       frac;
	} temp_fix_s;

	// ==========================================================
	function automatic logic hits_reg(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
		logic [ADR_W-1:0] byte_adr;
		byte_adr = {idx[ADR_W-3:0], 2'b00};
		return adr == byte_adr;
	endfunction : hits_reg

endpackage : ext_temp_pkg

// [wb_classic_slave.sv]
`timescale 1ns/10ps
module wb_classic_slave
	import ext_temp_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [SEL_W-1:0] wb_sel_i,
	input  wire logic [DAT_W-1:0] wb_dat_i,
	output logic      [DAT_W-1:0] wb_dat_o,
	output logic                  wb_ack_o,
	output bus_req_s              req_o,
	output logic                  wr_commit_o,
	input  wire logic [DAT_W-1:0] rdata_i
);

	bus_state_e       state_reg;
	bus_state_e       state_next;
	logic [DAT_W-1:0] dat_reg;
	logic [DAT_W-1:0] dat_next;
	logic             take;

	// ==========================================================
	// Request capture: read data sampled on take, write on ack edge
	always_comb begin
		take        = ce && wb_cyc_i && wb_stb_i && (state_reg == BUS_IDLE);
		state_next  = state_reg;
		dat_next    = dat_reg;
		wr_commit_o = 1'b0;
		case (state_reg)
			BUS_IDLE: begin
				if (take) begin
					state_next = BUS_ACK;
					dat_next   = wb_we_i ? dat_reg : rdata_i;
				end
			end
			BUS_ACK: begin
				if (ce) begin
					state_next  = BUS_IDLE;
					wr_commit_o = wb_cyc_i && wb_stb_i && wb_we_i;
				end
			end
			default: state_next = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= BUS_IDLE;
			dat_reg   <= '0;
		end else begin
			state_reg <= state_next;
			dat_reg   <= dat_next;
		end
	end

	assign req_o    = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
	assign wb_ack_o = (state_reg == BUS_ACK);
	assign wb_dat_o = dat_reg;

endmodule : wb_classic_slave

// [buffered_reg.sv]
`timescale 1ns/10ps
module buffered_reg
	import ext_temp_pkg::*;
#(
	parameter int         W   = BYTE_W,
	parameter logic [W-1:0] RST = '0
)(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wr_data_i,
	input  wire logic         update_i,
	output logic      [W-1:0] shadow_o,
	output logic      [W-1:0] active_o
);

	logic [W-1:0] shadow_reg;
	logic [W-1:0] shadow_next;
	logic [W-1:0] active_reg;
	logic [W-1:0] active_next;

	// ==========================================================
	// Writes land in the shadow; update moves the old shadow out
	always_comb begin
		shadow_next = shadow_reg;
		active_next = active_reg;
		if (ce && wr_i) begin
			shadow_next = wr_data_i;
		end
		if (ce && update_i) begin
			active_next = shadow_reg;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shadow_reg <= RST;
			active_reg <= RST;
		end else begin
			shadow_reg <= shadow_next;
			active_reg <= active_next;
		end
	end

	assign shadow_o = shadow_reg;
	assign active_o = active_reg;

endmodule : buffered_reg

// [external_temp_input_regs.sv]
// What this block does
// - Software writes a signed 16-bit remote sensor temperature for compensation.
// - Bits 6..0 are the fraction, bits 14..7 the integer degrees Celsius.
// - Low byte register holds bits 7..0, high byte register bits 15..8.
// - Written bytes wait in a shadow until an I/O update; the io_update input pulse applies them.
// - Source register bit 2 picks the temperature for channel two offset compensation.
// - Bit 2 low uses the internal sensor, high uses the written field.
// - Both temperature bytes and the select bit reset to zero.
`timescale 1ns/10ps
module external_temp_input_regs
	import ext_temp_pkg::*;
#(
	parameter int AW = ADR_W
)(
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	input  wire logic                     io_update,
	input  wire logic signed [TEMP_W-1:0] internal_temp_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic        [AW-1:0]     wb_adr_i,
	input  wire logic        [SEL_W-1:0]  wb_sel_i,
	input  wire logic        [DAT_W-1:0]  wb_dat_i,
	output logic             [DAT_W-1:0]  wb_dat_o,
	output logic                          wb_ack_o,
	output logic signed      [TEMP_W-1:0] ext_temp_o,
	output temp_fix_s                     ext_temp_fix_o,
	output logic signed      [TEMP_W-1:0] second_digital_pll_channel_temp_o,
	output logic                          second_digital_pll_channel_uses_ext_o,
	output logic                          update_pending_o
);

	// ==========================================================
	// Bus slave
	bus_req_s         req;
	logic             wr_commit;
	logic [DAT_W-1:0] rdata;

	wb_classic_slave u_bus (
		.clk         (clk),
		.resetn      (resetn),
		.ce          (ce),
		.wb_cyc_i    (wb_cyc_i),
		.wb_stb_i    (wb_stb_i),
		.wb_we_i     (wb_we_i),
		.wb_adr_i    (wb_adr_i),
		.wb_sel_i    (wb_sel_i),
		.wb_dat_i    (wb_dat_i),
		.wb_dat_o    (wb_dat_o),
		.wb_ack_o    (wb_ack_o),
		.req_o       (req),
		.wr_commit_o (wr_commit),
		.rdata_i     (rdata)
	);

	// ==========================================================
	// Write decode, lane 0 carries every byte-wide register
	logic wr_lane0;
	logic wr_low;
	logic wr_high;
	logic wr_src;

	assign wr_lane0 = wr_commit && req.sel[LANE0];
	assign wr_low   = wr_lane0 && hits_reg(req.adr, IDX_TEMP_LOW);
	assign wr_high  = wr_lane0 && hits_reg(req.adr, IDX_TEMP_HIGH);
	assign wr_src   = wr_lane0 && hits_reg(req.adr, IDX_SRC_SEL);

	// ==========================================================
	// Buffered temperature bytes
	logic [BYTE_W-1:0] low_shadow;
	logic [BYTE_W-1:0] low_active;
	logic [BYTE_W-1:0] high_shadow;
	logic [BYTE_W-1:0] high_active;

	buffered_reg #(.W(BYTE_W), .RST(RST_TEMP_BYTE)) u_low (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.wr_i      (wr_low),
		.wr_data_i (req.dat[BYTE_W-1:0]),
		.update_i  (io_update),
		.shadow_o  (low_shadow),
		.active_o  (low_active)
	);

	buffered_reg #(.W(BYTE_W), .RST(RST_TEMP_BYTE)) u_high (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.wr_i      (wr_high),
		.wr_data_i (req.dat[BYTE_W-1:0]),
		.update_i  (io_update),
		.shadow_o  (high_shadow),
		.active_o  (high_active)
	);

	logic signed [TEMP_W-1:0] ext_shadow;
	logic signed [TEMP_W-1:0] ext_active;

	assign ext_shadow = {high_shadow, low_shadow};
	assign ext_active = {high_active, low_active};

	// ==========================================================
	// Source select, pending flag and compensation output
	logic [BYTE_W-1:0]        src_reg;
	logic [BYTE_W-1:0]        src_next;
	logic                     pend_reg;
	logic                     pend_next;
	logic signed [TEMP_W-1:0] comp_reg;
	logic signed [TEMP_W-1:0] comp_next;

	always_comb begin
		src_next  = src_reg;
		pend_next = pend_reg;
		comp_next = comp_reg;
		if (ce) begin
			if (wr_src) begin
				src_next              = RST_SRC_SEL;
				src_next[SEL_CH2_BIT] = req.dat[SEL_CH2_BIT];
			end
			// A write in the update cycle keeps the flag set
			if (io_update) begin
				pend_next = 1'b0;
			end
			if (wr_low || wr_high) begin
				pend_next = 1'b1;
			end
			comp_next = src_reg[SEL_CH2_BIT] ? ext_active : internal_temp_i;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			src_reg  <= RST_SRC_SEL;
			pend_reg <= 1'b0;
			comp_reg <= '0;
		end else begin
			src_reg  <= src_next;
			pend_reg <= pend_next;
			comp_reg <= comp_next;
		end
	end

	// ==========================================================
	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata = '0;
		if (hits_reg(req.adr, IDX_TEMP_LOW)) begin
			rdata[BYTE_W-1:0] = low_shadow;
		end else if (hits_reg(req.adr, IDX_TEMP_HIGH)) begin
			rdata[BYTE_W-1:0] = high_shadow;
		end else if (hits_reg(req.adr, IDX_SRC_SEL)) begin
			rdata[BYTE_W-1:0] = src_reg;
		end else if (hits_reg(req.adr, IDX_TEMP_STAT)) begin
			rdata[TEMP_W-1:0]    = ext_active;
			rdata[STAT_PEND_BIT] = pend_reg;
		end
	end

	// ==========================================================
	// Outputs
	assign ext_temp_o                            = ext_active;
	assign ext_temp_fix_o.whole                  = ext_active[INT_MSB:INT_LSB];
	assign ext_temp_fix_o.frac                   = ext_active[FRAC_MSB:0];
	assign second_digital_pll_channel_temp_o     = comp_reg;
	assign second_digital_pll_channel_uses_ext_o = src_reg[SEL_CH2_BIT];
	assign update_pending_o                      = pend_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_bus_write(logic [15:0] idx);
		ce && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[LANE0]
			&& hits_reg(wb_adr_i, idx);
	endsequence

	sequence s_update;
		ce && io_update;
	endsequence

	sequence s_bus_take;
		ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	property p_byte_lands(logic [15:0] idx, logic [BYTE_W-1:0] shadow);
		logic [BYTE_W-1:0] d;
		(s_bus_write(idx), d = wb_dat_i[BYTE_W-1:0]) |=> shadow == d;
	endproperty

	AST_FIELD_IS_BYTES: assert property (
		ext_temp_o == $signed({high_active, low_active}))
		else $error("active field is not high byte over low byte");

	AST_FIX_PARTS: assert property (
		ext_temp_fix_o.whole == ext_temp_o[INT_MSB:INT_LSB]
			&& ext_temp_fix_o.frac == ext_temp_o[FRAC_MSB:0])
		else $error("fixed point split is wrong");

	AST_LOW_WRITE: assert property (p_byte_lands(IDX_TEMP_LOW, low_shadow))
		else $error("low byte write not stored");

	AST_HIGH_WRITE: assert property (p_byte_lands(IDX_TEMP_HIGH, high_shadow))
		else $error("high byte write not stored");

	AST_UPDATE_MOVES: assert property (
		s_update |=> ext_active == $past(ext_shadow))
		else $error("update did not move shadow to active");

	AST_NO_EARLY_EFFECT: assert property (
		!(ce && io_update) |=> $stable(ext_active))
		else $error("active value changed without update");

	AST_WRITE_THEN_UPDATE: assert property (
		s_bus_write(IDX_TEMP_LOW) ##1 (!io_update [*2]) ##1 s_update
			|=> low_active == $past(low_shadow) && !update_pending_o)
		else $error("written low byte not applied by update");

	AST_SELECT_PATH: assert property (
		resetn && ce |=> second_digital_pll_channel_temp_o ==
			($past(src_reg[SEL_CH2_BIT]) ? $past(ext_active) : $past(internal_temp_i)))
		else $error("compensation source mux wrong");

	AST_SELECT_WRITE: assert property (
		s_bus_write(IDX_SRC_SEL) |=> second_digital_pll_channel_uses_ext_o == $past(wb_dat_i[2]))
		else $error("select bit not written");

	AST_RESERVED_ZERO: assert property (
		src_reg[BYTE_W-1:SEL_CH2_BIT+1] == '0 && src_reg[SEL_CH2_BIT-1:0] == '0)
		else $error("reserved select bits not zero");

	AST_RESET_STATE: assert property (
		$rose(resetn) |-> src_reg == RST_SRC_SEL && ext_active == '0 && ext_shadow == '0)
		else $error("reset values not zero");

	AST_ACK_TIMING: assert property (
		s_bus_take |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce)))
		else $error("bus ack not a single cycle after request");

	AST_FROZEN: assert property (
		!ce |=> $stable(src_reg) && $stable(ext_shadow) && $stable(wb_ack_o))
		else $error("state moved while clock enable low");

endmodule : external_temp_input_regs

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	import ext_temp_pkg::*;

	// ==========================================================
	// Bench signals
	localparam logic [15:0] A_LOW          = {IDX_TEMP_LOW[13:0], 2'b00};
	localparam logic [15:0] A_HIGH         = {IDX_TEMP_HIGH[13:0], 2'b00};
	localparam logic [15:0] A_SEL          = {IDX_SRC_SEL[13:0], 2'b00};
	localparam logic [15:0] A_STAT         = {IDX_TEMP_STAT[13:0], 2'b00};
	localparam logic [15:0] A_NONE         = 16'hA4FC;
	localparam logic [15:0] INT_TEMP       = 16'h0A80;
	localparam int          TIMEOUT_CYCLES = 5000;

	logic                     clk;
	logic                     resetn;
	logic                     ce;
	logic                     io_update;
	logic signed [TEMP_W-1:0] internal_temp_i;
	logic                     wb_cyc_i;
	logic                     wb_stb_i;
	logic                     wb_we_i;
	logic        [ADR_W-1:0]  wb_adr_i;
	logic        [SEL_W-1:0]  wb_sel_i;
	logic        [DAT_W-1:0]  wb_dat_i;
	logic        [DAT_W-1:0]  wb_dat_o;
	logic                     wb_ack_o;
	logic signed [TEMP_W-1:0] ext_temp_o;
	temp_fix_s                ext_temp_fix_o;
	logic signed [TEMP_W-1:0] comp_temp;
	logic                     uses_ext;
	logic                     update_pending_o;
	int                       num_errors;
	int                       total_checks;
	int                       cycles;

	external_temp_input_regs external_temp_input_regs_i (
		.clk                                   (clk),
		.resetn                                (resetn),
		.ce                                    (ce),
		.io_update                             (io_update),
		.internal_temp_i                       (internal_temp_i),
		.wb_cyc_i                              (wb_cyc_i),
		.wb_stb_i                              (wb_stb_i),
		.wb_we_i                               (wb_we_i),
		.wb_adr_i                              (wb_adr_i),
		.wb_sel_i                              (wb_sel_i),
		.wb_dat_i                              (wb_dat_i),
		.wb_dat_o                              (wb_dat_o),
		.wb_ack_o                              (wb_ack_o),
		.ext_temp_o                            (ext_temp_o),
		.ext_temp_fix_o                        (ext_temp_fix_o),
		.second_digital_pll_channel_temp_o     (comp_temp),
		.second_digital_pll_channel_uses_ext_o (uses_ext),
		.update_pending_o                      (update_pending_o)
	);

	// ==========================================================
	// Clock, time limit and verdict
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT_CYCLES) begin
			num_errors = num_errors + 1;
			$display("Error at %0t: run took too long", $time);
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Checks made: %0d, mismatches: %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// ==========================================================
	// Bus and update helpers
	task automatic wb_xfer(input logic we, input logic [15:0] adr, input logic [31:0] dat,
			input logic [3:0] sel, output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk);
	endtask : wb_xfer

	task automatic pulse_update();
		io_update <= 1'b1;
		@(posedge clk);
		io_update <= 1'b0;
		@(posedge clk);
	endtask : pulse_update

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		logic [31:0] rd;
		check({31'h0, uses_ext}, 32'h0, "select after reset");
		check({16'h0, ext_temp_o}, 32'h0, "active temp after reset");
		check({16'h0, comp_temp}, {16'h0, INT_TEMP}, "internal used");
		wb_xfer(1'b0, A_LOW, 32'h0, 4'hF, rd);
		check(rd, 32'h0, "low byte reset");
		wb_xfer(1'b0, A_HIGH, 32'h0, 4'hF, rd);
		check(rd, 32'h0, "high byte reset");
		wb_xfer(1'b0, A_SEL, 32'h0, 4'hF, rd);
		check(rd, 32'h0, "select reset");
		$display("test reset done");
	endtask : test_reset

	task automatic test_temp(input logic [15:0] t, input logic [15:0] prev);
		logic [31:0] rd;
		wb_xfer(1'b1, A_LOW, {24'h0, t[7:0]}, 4'h1, rd);
		wb_xfer(1'b1, A_HIGH, {24'h0, t[15:8]}, 4'h1, rd);
		wb_xfer(1'b0, A_LOW, 32'h0, 4'hF, rd);
		check(rd, {24'h0, t[7:0]}, "low byte shadow");
		wb_xfer(1'b0, A_HIGH, 32'h0, 4'hF, rd);
		check(rd, {24'h0, t[15:8]}, "high byte shadow");
		check({16'h0, ext_temp_o}, {16'h0, prev}, "held before update");
		check({31'h0, update_pending_o}, 32'h1, "pending set");
		pulse_update();
		check({16'h0, ext_temp_o}, {16'h0, t}, "active temp");
		check({24'h0, ext_temp_fix_o.whole}, {24'h0, t[14:7]}, "integer part");
		check({25'h0, ext_temp_fix_o.frac}, {25'h0, t[6:0]}, "fraction part");
		check({31'h0, update_pending_o}, 32'h0, "pending cleared");
		wb_xfer(1'b0, A_STAT, 32'h0, 4'hF, rd);
		check(rd, {16'h0, t}, "status readback");
		$display("test temperature %h done", t);
	endtask : test_temp

	task automatic test_select(input logic [15:0] t);
		logic [31:0] rd;
		wb_xfer(1'b1, A_SEL, 32'h0000_00FF, 4'h1, rd);
		wb_xfer(1'b0, A_SEL, 32'h0, 4'hF, rd);
		check(rd, 32'h0000_0004, "reserved bits read zero");
		check({31'h0, uses_ext}, 32'h1, "select bit set");
		check({16'h0, comp_temp}, {16'h0, t}, "external used");
		wb_xfer(1'b1, A_SEL, 32'h0000_0000, 4'h1, rd);
		@(posedge clk);
		check({31'h0, uses_ext}, 32'h0, "select bit clear");
		check({16'h0, comp_temp}, {16'h0, INT_TEMP}, "internal again");
		$display("test select done");
	endtask : test_select

	task automatic test_odd_access(input logic [15:0] t);
		logic [31:0] rd;
		wb_xfer(1'b1, A_LOW, 32'h0000_0055, 4'hE, rd);
		wb_xfer(1'b0, A_LOW, 32'h0, 4'hF, rd);
		check(rd, {24'h0, t[7:0]}, "lane zero off ignored");
		wb_xfer(1'b1, A_NONE, 32'h0000_00AA, 4'hF, rd);
		wb_xfer(1'b0, A_NONE, 32'h0, 4'hF, rd);
		check(rd, 32'h0, "unmapped reads zero");
		$display("test odd access done");
	endtask : test_odd_access

	// Update two idle cycles after the last byte write
	task automatic test_quick_update(input logic [15:0] t);
		logic [31:0] rd;
		wb_xfer(1'b1, A_HIGH, {24'h0, t[15:8]}, 4'h1, rd);
		wb_xfer(1'b1, A_LOW, {24'h0, t[7:0]}, 4'h1, rd);
		@(posedge clk);
		pulse_update();
		check({16'h0, ext_temp_o}, {16'h0, t}, "quick update");
		check({31'h0, update_pending_o}, 32'h0, "quick pending");
		$display("test quick update done");
	endtask : test_quick_update

	// Clock enable low ignores update; then a reset in mid-run
	task automatic test_freeze(input logic [15:0] t);
		logic [31:0] rd;
		wb_xfer(1'b1, A_LOW, 32'h0000_0012, 4'h1, rd);
		ce        <= 1'b0;
		io_update <= 1'b1;
		@(posedge clk);
		ce        <= 1'b1;
		io_update <= 1'b0;
		@(posedge clk);
		check({16'h0, ext_temp_o}, {16'h0, t}, "frozen update");
		check({31'h0, update_pending_o}, 32'h1, "frozen pending");
		pulse_update();
		check({16'h0, ext_temp_o}, {16'h0, t[15:8], 8'h12}, "update after freeze");
		wb_xfer(1'b1, A_SEL, 32'h0000_0004, 4'h1, rd);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		check({16'h0, ext_temp_o}, 32'h0, "temp after reset");
		check({31'h0, uses_ext}, 32'h0, "select after mid reset");
		check({31'h0, update_pending_o}, 32'h0, "pending after reset");
		check({16'h0, comp_temp}, {16'h0, INT_TEMP}, "internal after reset");
		$display("test freeze and reset done");
	endtask : test_freeze

	// ==========================================================
	// Main sequence
	initial begin
		num_errors      = 0;
		total_checks    = 0;
		cycles          = 0;
		resetn          = 1'b0;
		ce              = 1'b1;
		io_update       = 1'b0;
		internal_temp_i = INT_TEMP;
		wb_cyc_i        = 1'b0;
		wb_stb_i        = 1'b0;
		wb_we_i         = 1'b0;
		wb_adr_i        = 16'h0000;
		wb_sel_i        = 4'h0;
		wb_dat_i        = 32'h0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		test_reset();
		test_temp(16'hF833, 16'h0000);
		test_select(16'hF833);
		test_temp(16'h118D, 16'hF833);
		test_odd_access(16'h118D);
		test_quick_update(16'hF833);
		test_freeze(16'hF833);
		give_verdict();
	end

endmodule : tb_top
